// [test_transceiver_global_register_map.sv]
// testbench: random and corner register traffic against the global register bank
module test_transceiver_global_register_map
	import tgr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] ID = 8'h3c;	// arbitrary identification value
	localparam logic [7:0] RWL [9] = '{OFS_XCVR_CTL1, OFS_FRM_CTL, OFS_XCVR_CTL2, OFS_XCVR_CLK,
		OFS_LIF_SRST, OFS_FRM_SRST, OFS_FRM_IMR, OFS_TST_IMR, OFS_LIF_IMR};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic [3:0]  pstrb;
	logic [7:0]  ev [3];
	logic [7:0]  fwd_rdata, r, m;
	logic [7:0]  v [9];
	tgr_ctl_s    ctl;
	tgr_fwd_s    fwd;
	int          n_fail, checked;
	tgr_host host_inst (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));
	tgr_bank #(.DEV_ID(ID)) tgr_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_event(ev[0]),
		.tst_event(ev[1]), .lif_event(ev[2]), .fwd_rdata(fwd_rdata), .ctl(ctl), .fwd(fwd),
		.irq(irq));
	// xorshift source, seeded at 12 so runs repeat
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// byte address of a register index; bits eleven to thirteen stay zero
	function automatic logic [15:0] ba(input logic [12:0] i);
		return {1'b0, i[12], 3'b000, i[8:0], 2'b00};
	endfunction
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	// a hung transfer counts as a mismatch and ends the run
	task automatic rw(input logic w, input logic [12:0] i, input logic [7:0] d);
		logic t;
		host_inst.xfer(w, ba(i), d, r, e, t);
		if (t)
		begin
			n_fail++;
			test_done();
		end
	endtask
	// irq is combinational, so look at it away from the edge
	task automatic irq_is(input logic x);
		@(negedge pclk);
		chk("irq", irq, x);
	endtask
	initial
	begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	// main sequence
	initial
	begin
		presetn = 0;
		ev = '{default: 8'h00};
		fwd_rdata = 8'h00;
		seed = 32'h0000_000c;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		foreach (RWL[k])
		begin
			rw(0, RWL[k], 0);
			chk("reset", r, 0);
		end
		rw(0, OFS_DEV_ID, 0);
		chk("id", r, ID);
		$display("reset test done");
		foreach (RWL[k])
		begin
			v[k] = 8'(rnd());
			rw(1, RWL[k], v[k]);
			rw(0, RWL[k], 0);
			chk("rw", r, v[k]);
		end
		chk("ctl_hi", ctl[47:24], {v[0], v[1], v[2]});
		chk("ctl_lo", ctl[23:0], {v[3], v[4], v[5]});
		foreach (RWL[k])
			rw(1, RWL[k], 0);
		$display("read write test done");
		rw(1, OFS_RSVD_F4, 0);
		rw(0, OFS_RSVD_F4, 0);
		chk("rsvd", r, 0);
		rw(1, OFS_DEV_ID, 8'(rnd()));
		rw(0, OFS_DEV_ID, 0);
		chk("id_ro", r, ID);
		host_inst.xfer(1, 16'h2000, 8'hff, r, e, m[0]);
		chk("unmapped", e, 1);
		chk("hang", m[0], 0);
		fwd_rdata <= 8'(rnd());
		// offsets stay inside the transmit framer window, which ends at ef
		rw(0, TGR_TXF_LO + 13'(rnd() & 32'h0ef), 0);
		chk("fwd", r, fwd_rdata);
		chk("fwd_region", fwd.region, TGR_REG_TXF);
		$display("decode test done");
		for (int i = 0; i < 3; i++)
		begin
			m = 8'h01 << 3'(rnd());
			@(posedge pclk);
			ev[i] <= m;
			@(posedge pclk);
			ev[i] <= 0;
			rw(0, OFS_FRM_ISR + 8'(i), 0);
			chk("status", r, m);
			irq_is(1);
			rw(1, OFS_FRM_IMR + 8'(i), m);
			irq_is(0);
			rw(1, OFS_FRM_IMR + 8'(i), 0);
			rw(1, OFS_FRM_LSR + 13'(i), 0);
			rw(0, OFS_FRM_LSR + 13'(i), 0);
			chk("latched", r, m);
			rw(1, OFS_FRM_LMR + 13'(i), m);
			rw(0, OFS_FRM_ISR + 8'(i), 0);
			chk("lmask", r, 0);
			rw(1, OFS_FRM_LMR + 13'(i), 0);
			rw(1, OFS_FRM_LSR + 13'(i), m);
			rw(0, OFS_FRM_ISR + 8'(i), 0);
			chk("cleared", r, 0);
			irq_is(0);
		end
		$display("interrupt test done");
		test_done();
	end
endmodule // test_transceiver_global_register_map
bind tgr_bank tgr_bank_checker tgr_bank_checker_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .frm_event(frm_event), .tst_event(tst_event), .lif_event(lif_event),
	.ctl(ctl), .fwd(fwd), .irq(irq));

// [tgr_bank.sv]
// module: APB slave holding the global register bank, address decode and interrupt summary
//
// Decided for this implementation: the APB slave port.
module tgr_bank
	import tgr_pkg::*;
#(
	parameter logic [7:0] DEV_ID = 8'h00a5	// arbitrary identification value
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  frm_event,
	input  wire logic [7:0]  tst_event,
	input  wire logic [7:0]  lif_event,
	input  wire logic [7:0]  fwd_rdata,
	output tgr_ctl_s         ctl,
	output tgr_fwd_s         fwd,
	output logic             irq
);
	logic [7:0]  xcvr_ctl1_q;
	logic [7:0]  frm_ctl_q;
	logic [7:0]  xcvr_ctl2_q;
	logic [7:0]  xcvr_clk_q;
	logic [7:0]  lif_srst_q;
	logic [7:0]  frm_srst_q;
	logic [7:0]  frm_imr_q;
	logic [7:0]  tst_imr_q;
	logic [7:0]  lif_imr_q;
	logic [7:0]  frm_lsr_q;
	logic [7:0]  tst_lsr_q;
	logic [7:0]  lif_lsr_q;
	logic [7:0]  frm_lmr_q;
	logic [7:0]  tst_lmr_q;
	logic [7:0]  lif_lmr_q;
	logic [7:0]  frm_isr;
	logic [7:0]  tst_isr;
	logic [7:0]  lif_isr;
	logic [12:0] dev_addr;
	logic        word_ok;
	logic        hole;
	logic [5:0]  region;
	logic        glb_hit;
	logic        lsr_hit;
	logic        access;
	logic        wr_en;
	logic        byte0;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        rsel_ok;
	logic        unmapped;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	tgr_state_e  state_q;

	// bits nine-eleven zero
	// word index from byte address; bits 9..11 have no pin so any one there is unmapped
	assign dev_addr = {paddr[14], 3'b000, paddr[10:2]};
	assign word_ok  = (paddr[1:0] == 2'b00) && (paddr[15] == 1'b0);
	assign hole     = (paddr[13:11] != 3'b000);

	always_comb
	begin
		region = 6'b000000;
		if (word_ok && !hole)
		begin
			if (dev_addr <= TGR_RXF_HI)
				region = TGR_REG_RXF;
			else if (dev_addr >= TGR_GLB_LO && dev_addr <= TGR_GLB_HI)
				region = TGR_REG_GLB;
			else if (dev_addr >= TGR_TXF_LO && dev_addr <= TGR_TXF_HI)
				region = TGR_REG_TXF;
			else if (dev_addr >= TGR_LIF_LO && dev_addr <= TGR_LIF_HI)
				region = TGR_REG_LIF;
			else if (dev_addr >= TGR_TST_LO && dev_addr <= TGR_TST_HI)
				region = TGR_REG_TST;
			else if (dev_addr >= TGR_BER_LO && dev_addr <= TGR_BER_HI)
				region = TGR_REG_BER;
			else
				region = 6'b000000;
		end
	end

	assign glb_hit = (region == TGR_REG_GLB);
	assign lsr_hit = word_ok && !hole && (dev_addr >= OFS_FRM_LSR) && (dev_addr <= OFS_LIF_LMR);
	assign access  = psel && penable && (state_q == TGR_ST_IDLE);
	assign byte0   = pstrb[0];
	assign wr_en   = access && pwrite && byte0 && !unmapped;
	assign wbyte   = pwdata[7:0];

	// unmapped words answer with an error; reads and writes of holes have no effect
	// a plain net, so the write enable follows every change of the decode
	assign unmapped = (region == 6'b000000) && !lsr_hit;

	// status is the bitwise AND of latched bits with the inverted latch mask
	// latch mask hides bits from information
	always_comb
	begin
		frm_isr = 8'h0000;
		tst_isr = 8'h0000;
		lif_isr = 8'h0000;
		for (int i = 0; i < 8; i++)
		begin
			frm_isr[i] = frm_lsr_q[i] & ~frm_lmr_q[i];
			tst_isr[i] = tst_lsr_q[i] & ~tst_lmr_q[i];
			lif_isr[i] = lif_lsr_q[i] & ~lif_lmr_q[i];
		end
	end

	// global mask gates the status onto irq
	assign irq = |(frm_isr & ~frm_imr_q) | |(tst_isr & ~tst_imr_q) | |(lif_isr & ~lif_imr_q);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xcvr_ctl1_q <= RST_CTL;
			frm_ctl_q   <= RST_CTL;
			xcvr_ctl2_q <= RST_CTL;
			xcvr_clk_q  <= RST_CTL;
			lif_srst_q  <= RST_CTL;
			frm_srst_q  <= RST_CTL;
		end
		else if (wr_en && glb_hit)
		begin
			case (dev_addr[7:0])
				OFS_XCVR_CTL1: xcvr_ctl1_q <= wbyte;
				OFS_FRM_CTL:   frm_ctl_q   <= wbyte;
				OFS_XCVR_CTL2: xcvr_ctl2_q <= wbyte;
				OFS_XCVR_CLK:  xcvr_clk_q  <= wbyte;
				OFS_LIF_SRST:  lif_srst_q  <= wbyte;
				OFS_FRM_SRST:  frm_srst_q  <= wbyte;
				default:       ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frm_imr_q <= RST_MASK;
			tst_imr_q <= RST_MASK;
			lif_imr_q <= RST_MASK;
		end
		else if (wr_en && glb_hit)
		begin
			case (dev_addr[7:0])
				OFS_FRM_IMR: frm_imr_q <= wbyte;
				OFS_TST_IMR: tst_imr_q <= wbyte;
				OFS_LIF_IMR: lif_imr_q <= wbyte;
				default:     ;
			endcase
		end
	end

	// latch masks for the per-source latched status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frm_lmr_q <= RST_LMASK;
			tst_lmr_q <= RST_LMASK;
			lif_lmr_q <= RST_LMASK;
		end
		else if (wr_en && lsr_hit)
		begin
			if (dev_addr == OFS_FRM_LMR)
				frm_lmr_q <= wbyte;
			if (dev_addr == OFS_TST_LMR)
				tst_lmr_q <= wbyte;
			if (dev_addr == OFS_LIF_LMR)
				lif_lmr_q <= wbyte;
		end
	end

	// write-one-to-clear, a new event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frm_lsr_q <= 8'h0000;
			tst_lsr_q <= 8'h0000;
			lif_lsr_q <= 8'h0000;
		end
		else
		begin
			frm_lsr_q <= (frm_lsr_q & ~((wr_en && dev_addr == OFS_FRM_LSR) ? wbyte : 8'h0000))
				| frm_event;
			tst_lsr_q <= (tst_lsr_q & ~((wr_en && dev_addr == OFS_TST_LSR) ? wbyte : 8'h0000))
				| tst_event;
			lif_lsr_q <= (lif_lsr_q & ~((wr_en && dev_addr == OFS_LIF_LSR) ? wbyte : 8'h0000))
				| lif_event;
		end
	end

	// read mux; reserved f4/f7 read zero, writes there are dropped
	// read-only id and status
	always_comb
	begin
		rbyte   = 8'h0000;
		rsel_ok = 1'b1;
		if (glb_hit)
		begin
			case (dev_addr[7:0])
				OFS_XCVR_CTL1: rbyte = xcvr_ctl1_q;
				OFS_FRM_CTL:   rbyte = frm_ctl_q;
				OFS_XCVR_CTL2: rbyte = xcvr_ctl2_q;
				OFS_XCVR_CLK:  rbyte = xcvr_clk_q;
				OFS_LIF_SRST:  rbyte = lif_srst_q;
				OFS_FRM_SRST:  rbyte = frm_srst_q;
				OFS_DEV_ID:    rbyte = DEV_ID;
				OFS_FRM_ISR:   rbyte = frm_isr;
				OFS_TST_ISR:   rbyte = tst_isr;
				OFS_LIF_ISR:   rbyte = lif_isr;
				OFS_FRM_IMR:   rbyte = frm_imr_q;
				OFS_TST_IMR:   rbyte = tst_imr_q;
				OFS_LIF_IMR:   rbyte = lif_imr_q;
				default:       rbyte = 8'h0000;
			endcase
		end
		else if (lsr_hit)
		begin
			case (dev_addr)
				OFS_FRM_LSR: rbyte = frm_lsr_q;
				OFS_TST_LSR: rbyte = tst_lsr_q;
				OFS_LIF_LSR: rbyte = lif_lsr_q;
				OFS_FRM_LMR: rbyte = frm_lmr_q;
				OFS_TST_LMR: rbyte = tst_lmr_q;
				OFS_LIF_LMR: rbyte = lif_lmr_q;
				default:     rbyte = 8'h0000;
			endcase
		end
		else if (region != 6'b000000)
			rbyte = fwd_rdata;
		else
			rsel_ok = 1'b0;
	end

	// forwarding of framer, line, test and tester accesses during the access phase
	// region tag on forwarded access
	assign fwd.sel    = access && (region != 6'b000000) && !glb_hit;
	assign fwd.wr     = pwrite && byte0;
	assign fwd.addr   = dev_addr;
	assign fwd.wdata  = wbyte;
	assign fwd.region = region;

	assign ctl.xcvr_ctl1 = xcvr_ctl1_q;
	assign ctl.frm_ctl   = frm_ctl_q;
	assign ctl.xcvr_ctl2 = xcvr_ctl2_q;
	assign ctl.xcvr_clk  = xcvr_clk_q;
	assign ctl.lif_srst  = lif_srst_q;
	assign ctl.frm_srst  = frm_srst_q;

	// one wait state: the answer is registered so read data comes from flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q   <= TGR_ST_IDLE;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				TGR_ST_IDLE:
				begin
					if (access)
					begin
						state_q   <= TGR_ST_DONE;
						prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
						pslverr_q <= !rsel_ok;
					end
				end
				TGR_ST_DONE:
				begin
					state_q   <= TGR_ST_IDLE;
					pslverr_q <= 1'b0;
				end
				default: state_q <= TGR_ST_IDLE;
			endcase
		end
	end

	assign pready  = (state_q == TGR_ST_DONE);
	assign pslverr = pready && pslverr_q;
	assign prdata  = prdata_q;
endmodule // tgr_bank

// [tgr_bank_checker.sv]
// checker: port-level timing, decode and interrupt properties of the global register bank
module tgr_bank_checker
	import tgr_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  frm_event,
	input wire logic [7:0]  tst_event,
	input wire logic [7:0]  lif_event,
	input wire tgr_ctl_s    ctl,
	input wire tgr_fwd_s    fwd,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// first access cycle, when the bank takes the request
	logic take;
	assign take = psel && penable && !pready;
	// helper terms keep the property lines short
	logic cause;
	logic glb_take;
	logic txf_fwd;
	assign cause    = ((frm_event | tst_event | lif_event) != 8'h00) || (take && pwrite);
	assign glb_take = take && !paddr[14] && (paddr[10:6] == 5'b01111);
	assign txf_fwd  = fwd.sel && !fwd.addr[12] && fwd.addr[8];
	sequence take_s;
		take;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	one_wait_a: assert property (take_s |=> answer_s)
		else $error("answer not one cycle after take");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	high_bits_a: assert property (take && paddr[13:11] != 3'b000 |=> pslverr)
		else $error("access with high address bits not refused");
	glb_local_a: assert property (glb_take |-> !fwd.sel)
		else $error("global access forwarded");
	txf_region_a: assert property (txf_fwd |-> fwd.region == TGR_REG_TXF)
		else $error("transmit framer region wrong");
	ctl_hold_a: assert property (!(take && pwrite) |=> $stable(ctl))
		else $error("control changed without write");
	irq_cause_a: assert property ($rose(irq) |-> $past(cause))
		else $error("interrupt rose without cause");
	irq_drop_a: assert property ($fell(irq) |-> $past(take && pwrite))
		else $error("interrupt fell without host write");
endmodule // tgr_bank_checker

// [tgr_host.sv]
// host model: apb master issuing one-byte register transfers
module tgr_host (
	input wire logic        pclk,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [15:0]     paddr,
	output logic [31:0]     pwdata,
	output logic [3:0]      pstrb
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus from time zero
	initial
	begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h1;
	end
	// software writes and reads one byte per word
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic e, output logic t);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata[7:0];
		e = pslverr;
		t = (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
endmodule // tgr_host

// [tgr_pkg.sv]
// package: address map, register offsets and carrier types for the global register bank
package tgr_pkg;
	// region bounds on the 13-bit device address
	localparam logic [12:0] TGR_RXF_LO   = 13'h0000;
	localparam logic [12:0] TGR_RXF_HI   = 13'h00ef;
	localparam logic [12:0] TGR_GLB_LO   = 13'h00f0;
	localparam logic [12:0] TGR_GLB_HI   = 13'h00ff;
	localparam logic [12:0] TGR_TXF_LO   = 13'h0100;
	localparam logic [12:0] TGR_TXF_HI   = 13'h01ef;
	localparam logic [12:0] TGR_LIF_LO   = 13'h1000;
	localparam logic [12:0] TGR_LIF_HI   = 13'h1017;
	localparam logic [12:0] TGR_TST_LO   = 13'h1018;
	localparam logic [12:0] TGR_TST_HI   = 13'h101f;
	localparam logic [12:0] TGR_BER_LO   = 13'h1100;
	localparam logic [12:0] TGR_BER_HI   = 13'h110f;
	// global register indices; byte address is four times the index
	localparam logic [7:0]  OFS_XCVR_CTL1   = 8'h00f0;
	localparam logic [7:0]  OFS_FRM_CTL     = 8'h00f1;
	localparam logic [7:0]  OFS_XCVR_CTL2   = 8'h00f2;
	localparam logic [7:0]  OFS_XCVR_CLK    = 8'h00f3;
	localparam logic [7:0]  OFS_RSVD_F4     = 8'h00f4;
	localparam logic [7:0]  OFS_LIF_SRST    = 8'h00f5;
	localparam logic [7:0]  OFS_FRM_SRST    = 8'h00f6;
	localparam logic [7:0]  OFS_RSVD_F7     = 8'h00f7;
	localparam logic [7:0]  OFS_DEV_ID      = 8'h00f8;
	localparam logic [7:0]  OFS_FRM_ISR     = 8'h00f9;
	localparam logic [7:0]  OFS_TST_ISR     = 8'h00fa;
	localparam logic [7:0]  OFS_LIF_ISR     = 8'h00fb;
	localparam logic [7:0]  OFS_FRM_IMR     = 8'h00fc;
	localparam logic [7:0]  OFS_TST_IMR     = 8'h00fd;
	localparam logic [7:0]  OFS_LIF_IMR     = 8'h00fe;
	// latched-status and latch-mask registers for the three sources, placed in a private window
	localparam logic [12:0] OFS_FRM_LSR     = 13'h1020;
	localparam logic [12:0] OFS_TST_LSR     = 13'h1021;
	localparam logic [12:0] OFS_LIF_LSR     = 13'h1022;
	localparam logic [12:0] OFS_FRM_LMR     = 13'h1024;
	localparam logic [12:0] OFS_TST_LMR     = 13'h1025;
	localparam logic [12:0] OFS_LIF_LMR     = 13'h1026;
	// reset values
	localparam logic [7:0]  RST_CTL         = 8'h0000;
	localparam logic [7:0]  RST_MASK        = 8'h0000;
	localparam logic [7:0]  RST_LMASK       = 8'h0000;
	// region one-hot codes returned on the region output
	typedef enum logic [5:0] {
		TGR_REG_RXF = 6'b000001,
		TGR_REG_GLB = 6'b000010,
		TGR_REG_TXF = 6'b000100,
		TGR_REG_LIF = 6'b001000,
		TGR_REG_TST = 6'b010000,
		TGR_REG_BER = 6'b100000
	} tgr_region_e;
	// bus access state
	typedef enum logic [1:0] {
		TGR_ST_IDLE = 2'b01,
		TGR_ST_DONE = 2'b10
	} tgr_state_e;
	// control outputs toward the transceiver, framer and line interface
	typedef struct packed {
		logic [7:0] xcvr_ctl1;
		logic [7:0] frm_ctl;
		logic [7:0] xcvr_ctl2;
		logic [7:0] xcvr_clk;
		logic [7:0] lif_srst;
		logic [7:0] frm_srst;
	} tgr_ctl_s;
	// access forwarded to a non-global region
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [12:0] addr;
		logic [7:0]  wdata;
		logic [5:0]  region;
	} tgr_fwd_s;
endpackage : tgr_pkg
